// [hw/bstu_map.svh]
/*
 * Register offsets, field positions, reset values and step constants of the
 * branch and soft-trap unit.
 * Assumes a 4 KiB APB window; offsets are byte addresses of aligned words.
 */
`ifndef BSTU_MAP_SVH
`define BSTU_MAP_SVH

`define BSTU_OFF_CMD 12'h000
`define BSTU_OFF_STATUS 12'h004
`define BSTU_OFF_CTRL 12'h008
`define BSTU_OFF_IP 12'h00c
`define BSTU_OFF_PSW 12'h010
`define BSTU_OFF_SSP 12'h014
`define BSTU_OFF_USP 12'h018
`define BSTU_OFF_TBR 12'h01c
`define BSTU_OFF_LINK 12'h020
`define BSTU_OFF_GPSRC 12'h024

`define BSTU_CMD_OP_LSB 0
`define BSTU_CMD_VEC_LSB 8
`define BSTU_CMD_OFF_LSB 16
`define BSTU_STAT_BUSY_BIT 0
`define BSTU_STAT_DONE_BIT 1
`define BSTU_CTRL_STEP_BIT 0

`define BSTU_PSW_NZVC_MSB 3
`define BSTU_PSW_I_BIT 4
`define BSTU_PSW_S_BIT 5
`define BSTU_PSW_ILM_LSB 16

`define BSTU_RST_IP 32'h0000_0000
`define BSTU_RST_PSW 32'h000f_0000
`define BSTU_RST_SSP 32'h0000_0000
`define BSTU_RST_USP 32'h0000_0000
`define BSTU_RST_TBR 32'h000f_fc00

`define BSTU_STACK_STEP 32'h0000_0004
`define BSTU_IP_STEP 32'h0000_0002
`define BSTU_VEC_TOP_OFF 32'h0000_03fc
`define BSTU_DEBUG_VEC_OFF 32'h0000_03d8
`define BSTU_DEBUG_ILM 5'h04
`define BSTU_TRAP_BASE_CYCLES 16'h0003

`endif

// [hw/bstu_pkg.sv]
/*
 * Types of the branch and soft-trap unit: operations, sequencer states and
 * the packed state records of both modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bstu_pkg;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_JUMP = 3'h1,
        OP_CALL_REL = 3'h2,
        OP_CALL_REG = 3'h3,
        OP_RETURN = 3'h4,
        OP_SOFT_TRAP = 3'h5,
        OP_DEBUG_TRAP = 3'h6
    } bstu_op_t;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_EX1 = 9'h002,
        ST_EX2 = 9'h004,
        ST_T1 = 9'h008,
        ST_WPS = 9'h010,
        ST_T2 = 9'h020,
        ST_WPC = 9'h040,
        ST_T3 = 9'h080,
        ST_WVEC = 9'h100
    } bstu_state_t;

    typedef struct packed {
        bstu_state_t st;
        bstu_op_t op;
        logic [31:0] ip;
        logic [31:0] psw;
        logic [31:0] system_stack_pointer;
        logic [31:0] usp;
        logic [31:0] vector_table_base;
        logic [31:0] link;
        logic [31:0] gpsrc;
        logic [7:0] vec;
        logic [10:0] boff;
        logic step;
        logic done;
        logic evt;
    } bstu_core_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bstu_port_t;

endpackage : bstu_pkg

// [hw/bstu_mem_if.sv]
/*
 * Carrier between the sequencer and its data memory port: one access
 * request and its completion.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface bstu_mem_if;
    logic start;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic done;
    logic [31:0] rdata;

    modport core (output start, output we, output addr, output wdata,
                  input done, input rdata);
    modport port (input start, input we, input addr, input wdata,
                  output done, output rdata);
endinterface : bstu_mem_if

`default_nettype wire

// [hw/bstu_mem_port.sv]
/*
 * Data memory port: turns a one-cycle start into a held request that ends
 * on the memory's acknowledge.
 * Assumes the memory runs on pclk and answers each request exactly once.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bstu_map.svh"

module bstu_mem_port (
    input wire logic pclk, // core clock
    input wire logic presetn, // asynchronous reset, low
    bstu_mem_if.port mp, // sequencer side
    output logic mem_req, // access request, held to ack
    output logic mem_we, // write when high
    output logic [31:0] mem_addr, // byte address
    output logic [31:0] mem_wdata, // write data
    input wire logic [31:0] mem_rdata, // read data, valid with ack
    input wire logic mem_ack // access complete
);
    import bstu_pkg::*;

    localparam bstu_port_t PORT_RST = '{req: 1'b0, we: 1'b0, addr: 32'h0, wdata: 32'h0};

    bstu_port_t q;
    bstu_port_t d;

    always_comb begin
        d = q;
        if (q.req && mem_ack) begin
            d.req = 1'b0;
        end
        if (mp.start) begin
            d.req = 1'b1;
            d.we = mp.we;
            d.addr = mp.addr;
            d.wdata = mp.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= PORT_RST;
        end else begin
            q <= d;
        end
    end

    assign mp.done = q.req & mem_ack;
    assign mp.rdata = mem_rdata;
    assign mem_req = q.req;
    assign mem_we = q.we;
    assign mem_addr = q.addr;
    assign mem_wdata = q.wdata;

endmodule : bstu_mem_port

`default_nettype wire

// [hw/bstu_branch_trap.sv]
/*
 * Branch and soft-trap unit: non-delayed jump, calls and return, plus the
 * software trap and debug trap with stacking and vector fetch.
 * Assumes an APB master on pclk and a data memory on pclk behind mem_*.
 */
// Added by the designer: the register offsets and the APB slave port.
// Notes on behaviour
// - indirect jump loads ip from source register, two cycles, no slot
// - relative call: link gets ip+2, ip becomes ip+2+doubled signed offset
// - indirect call: link gets ip+2, ip from source register, two cycles
// - return copies link into ip in two cycles, no slot
// - jumps, calls and return leave N, Z, V, C untouched
// - trap pushes status at ssp-4, then ip+2 at ssp-8
// - software trap clears stack-select and interrupt-enable flags
// - software trap loads ip from base+3fc minus four times vector
// - both traps take three cycles plus three memory accesses
// - stacking always goes through the system stack pointer
// - debug trap stacks like software trap, keeps interrupt enable
// - debug trap sets interrupt level mask to four
// - debug trap loads ip from base+3d8, no slot
// - debug trap raises no step event while single-stepping
`timescale 1ns/10ps
`default_nettype none
`include "bstu_map.svh"

module bstu_branch_trap (
    input wire logic pclk, // core clock, 125 MHz
    input wire logic presetn, // asynchronous reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready, always high
    output logic pslverr, // apb error on unmapped address
    output logic mem_req, // data memory request
    output logic mem_we, // data memory write
    output logic [31:0] mem_addr, // data memory address
    output logic [31:0] mem_wdata, // data memory write data
    input wire logic [31:0] mem_rdata, // data memory read data
    input wire logic mem_ack, // data memory access done
    output logic [31:0] stack_pointer, // active stack pointer
    output logic exception_event // step event pulse
);
    import bstu_pkg::*;

    localparam bstu_core_t CORE_RST = '{
        st: ST_IDLE, op: OP_NONE, ip: `BSTU_RST_IP, psw: `BSTU_RST_PSW,
        system_stack_pointer: `BSTU_RST_SSP, usp: `BSTU_RST_USP, vector_table_base: `BSTU_RST_TBR,
        link: 32'h0, gpsrc: 32'h0, vec: 8'h0, boff: 11'h0,
        step: 1'b0, done: 1'b0, evt: 1'b0};

    bstu_core_t q;
    bstu_core_t d;
    bstu_mem_if mif();

    logic [11:0] off;
    logic hit;
    logic wr_acc;
    logic idle;
    logic go;
    logic cmd_ok;
    bstu_op_t cmd_op;

    function automatic logic [31:0] rel_target(input logic [31:0] ip,
                                               input logic [10:0] boff);
        return ip + `BSTU_IP_STEP + {{20{boff[10]}}, boff, 1'b0};
    endfunction : rel_target

    function automatic logic [31:0] vec_target(input logic [31:0] vector_table_base,
                                               input bstu_op_t op,
                                               input logic [7:0] vec);
        if (op == OP_DEBUG_TRAP) begin
            return vector_table_base + `BSTU_DEBUG_VEC_OFF;
        end
        return vector_table_base + `BSTU_VEC_TOP_OFF - {22'h0, vec, 2'b00};
    endfunction : vec_target

    function automatic logic map_hit(input logic [11:0] a);
        case (a)
            `BSTU_OFF_CMD, `BSTU_OFF_STATUS, `BSTU_OFF_CTRL, `BSTU_OFF_IP,
            `BSTU_OFF_PSW, `BSTU_OFF_SSP, `BSTU_OFF_USP, `BSTU_OFF_TBR,
            `BSTU_OFF_LINK, `BSTU_OFF_GPSRC: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : map_hit

    assign off = paddr[11:0];
    assign hit = map_hit(off) && (paddr[31:12] == 20'h0);
    assign wr_acc = psel & penable & pwrite & hit;
    assign idle = (q.st == ST_IDLE);
    assign cmd_op = bstu_op_t'(pwdata[`BSTU_CMD_OP_LSB +: 3]);
    assign cmd_ok = cmd_op inside {OP_JUMP, OP_CALL_REL, OP_CALL_REG, OP_RETURN,
                                   OP_SOFT_TRAP, OP_DEBUG_TRAP};
    assign go = wr_acc && idle && (off == `BSTU_OFF_CMD) && cmd_ok;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    always_comb begin
        prdata = 32'h0;
        if (psel && !pwrite && hit) begin
            case (off)
                `BSTU_OFF_STATUS: begin
                    prdata[`BSTU_STAT_BUSY_BIT] = ~idle;
                    prdata[`BSTU_STAT_DONE_BIT] = q.done;
                end
                `BSTU_OFF_CTRL: prdata[`BSTU_CTRL_STEP_BIT] = q.step;
                `BSTU_OFF_IP: prdata = q.ip;
                `BSTU_OFF_PSW: prdata = q.psw;
                `BSTU_OFF_SSP: prdata = q.system_stack_pointer;
                `BSTU_OFF_USP: prdata = q.usp;
                `BSTU_OFF_TBR: prdata = q.vector_table_base;
                `BSTU_OFF_LINK: prdata = q.link;
                `BSTU_OFF_GPSRC: prdata = q.gpsrc;
                default: prdata = 32'h0;
            endcase
        end
    end

    always_comb begin
        d = q;
        d.evt = 1'b0;
        mif.start = 1'b0;
        mif.we = 1'b0;
        mif.addr = 32'h0;
        mif.wdata = 32'h0;
        // step control may change at any time
        if (wr_acc && (off == `BSTU_OFF_CTRL)) begin
            d.step = pwdata[`BSTU_CTRL_STEP_BIT];
        end
        // architectural registers are frozen while an operation runs
        if (wr_acc && idle) begin
            case (off)
                `BSTU_OFF_IP: d.ip = pwdata;
                `BSTU_OFF_PSW: d.psw = pwdata;
                `BSTU_OFF_SSP: d.system_stack_pointer = pwdata;
                `BSTU_OFF_USP: d.usp = pwdata;
                `BSTU_OFF_TBR: d.vector_table_base = pwdata;
                `BSTU_OFF_LINK: d.link = pwdata;
                `BSTU_OFF_GPSRC: d.gpsrc = pwdata;
                default: ;
            endcase
        end
        if (go) begin
            d.op = cmd_op;
            d.vec = pwdata[`BSTU_CMD_VEC_LSB +: 8];
            d.boff = pwdata[`BSTU_CMD_OFF_LSB +: 11];
            d.done = 1'b0;
            if (cmd_op == OP_SOFT_TRAP || cmd_op == OP_DEBUG_TRAP) begin
                d.st = ST_T1;
            end else begin
                d.st = ST_EX1;
            end
        end
        case (q.st)
            ST_IDLE: ;
            ST_EX1: d.st = ST_EX2;
            ST_EX2: begin
                case (q.op)
                    OP_JUMP: d.ip = q.gpsrc;
                    OP_CALL_REL: begin
                        d.link = q.ip + `BSTU_IP_STEP;
                        d.ip = rel_target(q.ip, q.boff);
                    end
                    OP_CALL_REG: begin
                        d.link = q.ip + `BSTU_IP_STEP;
                        d.ip = q.gpsrc;
                    end
                    OP_RETURN: d.ip = q.link;
                    default: ;
                endcase
                d.st = ST_IDLE;
                d.done = 1'b1;
                d.evt = q.step;
            end
            ST_T1: begin
                d.system_stack_pointer = q.system_stack_pointer - `BSTU_STACK_STEP;
                mif.start = 1'b1;
                mif.we = 1'b1;
                mif.addr = q.system_stack_pointer - `BSTU_STACK_STEP;
                mif.wdata = q.psw;
                d.st = ST_WPS;
            end
            ST_WPS: begin
                if (mif.done) begin
                    d.st = ST_T2;
                end
            end
            ST_T2: begin
                d.system_stack_pointer = q.system_stack_pointer - `BSTU_STACK_STEP;
                mif.start = 1'b1;
                mif.we = 1'b1;
                mif.addr = q.system_stack_pointer - `BSTU_STACK_STEP;
                mif.wdata = q.ip + `BSTU_IP_STEP;
                d.st = ST_WPC;
            end
            ST_WPC: begin
                if (mif.done) begin
                    d.st = ST_T3;
                end
            end
            ST_T3: begin
                mif.start = 1'b1;
                mif.addr = vec_target(q.vector_table_base, q.op, q.vec);
                d.st = ST_WVEC;
            end
            ST_WVEC: begin
                if (mif.done) begin
                    d.ip = mif.rdata;
                    d.psw[`BSTU_PSW_S_BIT] = 1'b0;
                    if (q.op == OP_SOFT_TRAP) begin
                        d.psw[`BSTU_PSW_I_BIT] = 1'b0;
                    end else begin
                        d.psw[`BSTU_PSW_ILM_LSB +: 5] = `BSTU_DEBUG_ILM;
                    end
                    d.st = ST_IDLE;
                    d.done = 1'b1;
                    // no step event for debug trap
                    d.evt = q.step && (q.op != OP_DEBUG_TRAP);
                end
            end
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    bstu_mem_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .mp(mif),
        .mem_req(mem_req),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .mem_ack(mem_ack)
    );

    assign stack_pointer = q.psw[`BSTU_PSW_S_BIT] ? q.usp : q.system_stack_pointer;
    assign exception_event = q.evt;

    // cycle and memory-cycle counters for the trap timing check
    logic [15:0] cyc_q;
    logic [15:0] mcyc_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= 16'h0;
            mcyc_q <= 16'h0;
        end else if (go) begin
            cyc_q <= 16'h0;
            mcyc_q <= 16'h0;
        end else if (!idle) begin
            cyc_q <= cyc_q + 16'h1;
            if (mem_req) begin
                mcyc_q <= mcyc_q + 16'h1;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence go_op(bstu_op_t o);
        go && (cmd_op == o);
    endsequence

    sequence op_done;
        q.done && (q.st == ST_IDLE);
    endsequence

    sequence ps_push;
        (q.st == ST_WPS) && mem_req && mem_we && (mem_addr == q.system_stack_pointer) &&
            (mem_wdata == q.psw);
    endsequence

    sequence pc_push;
        (q.st == ST_WPC) && mem_req && mem_we && (mem_addr == q.system_stack_pointer) &&
            (mem_wdata == q.ip + `BSTU_IP_STEP);
    endsequence

    sequence trap_end(bstu_op_t o);
        (q.st == ST_WVEC) && mif.done && (q.op == o);
    endsequence

    jump_target_a: assert property (go_op(OP_JUMP) |-> ##1 !q.done ##2 op_done ##0 (q.ip == $past(q.gpsrc, 3))) else $error("jump target wrong");

    call_rel_a: assert property (go_op(OP_CALL_REL) |-> ##3 op_done ##0 ((q.link == $past(q.ip, 3) + 32'h2) && (q.ip == rel_target($past(q.ip, 3), $past(pwdata[26:16], 3))))) else $error("relative call wrong");

    call_reg_a: assert property (go_op(OP_CALL_REG) |-> ##3 op_done ##0 ((q.link == $past(q.ip, 3) + 32'h2) && (q.ip == $past(q.gpsrc, 3)))) else $error("indirect call wrong");

    return_a: assert property (go_op(OP_RETURN) |-> ##3 op_done ##0 (q.ip == $past(q.link, 3))) else $error("return target wrong");

    flags_kept_a: assert property (!idle |=> (q.psw[`BSTU_PSW_NZVC_MSB:0] == $past(q.psw[`BSTU_PSW_NZVC_MSB:0]))) else $error("condition flags changed");

    ps_stack_a: assert property ((q.st == ST_T1) |=> (q.system_stack_pointer == $past(q.system_stack_pointer) - 32'h4) ##0 ps_push) else $error("status push wrong");

    pc_stack_a: assert property ((q.st == ST_T2) |=> (q.system_stack_pointer == $past(q.system_stack_pointer) - 32'h4) ##0 pc_push) else $error("return address push wrong");

    soft_flags_a: assert property (trap_end(OP_SOFT_TRAP) |=> !q.psw[`BSTU_PSW_S_BIT] && !q.psw[`BSTU_PSW_I_BIT]) else $error("soft trap flags wrong");

    soft_vector_a: assert property ((q.st == ST_T3 && q.op == OP_SOFT_TRAP) |=> mem_req && !mem_we && (mem_addr == q.vector_table_base + 32'h3fc - {22'h0, q.vec, 2'b00})) else $error("soft vector address wrong");

    vector_load_a: assert property (((q.st == ST_WVEC) && mif.done) |=> (q.ip == $past(mem_rdata)) ##0 op_done) else $error("vector not loaded");

    trap_time_a: assert property (((q.st == ST_WVEC) && mif.done) |-> (cyc_q == mcyc_q + `BSTU_TRAP_BASE_CYCLES)) else $error("trap cycle count wrong");

    system_stack_a: assert property ((q.st == ST_WVEC) && mif.done |=> (stack_pointer == q.system_stack_pointer)) else $error("system stack not active");

    debug_keep_i_a: assert property (trap_end(OP_DEBUG_TRAP) |=> !q.psw[`BSTU_PSW_S_BIT] && (q.psw[`BSTU_PSW_I_BIT] == $past(q.psw[`BSTU_PSW_I_BIT]))) else $error("debug trap touched enable");

    debug_level_a: assert property (trap_end(OP_DEBUG_TRAP) |=> (q.psw[20:16] == 5'h04)) else $error("debug level not four");

    debug_vector_a: assert property ((q.st == ST_T3 && q.op == OP_DEBUG_TRAP) |=> mem_req && (mem_addr == q.vector_table_base + 32'h3d8)) else $error("debug vector address wrong");

    debug_quiet_a: assert property (trap_end(OP_DEBUG_TRAP) |=> !exception_event) else $error("debug trap raised event");

    branch_steps_a: assert property ((q.st == ST_EX1) |=> (q.st == ST_EX2) ##1 op_done) else $error("branch not two cycles");

    mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("memory request dropped");

endmodule : bstu_branch_trap

`default_nettype wire

// [sim/bstu_mem_model.sv]
/*
 * Data memory model: system stack and vector table, with wait cycles.
 * Assumes requests held until ack, on pclk.
 */
`timescale 1ns/10ps
`default_nettype none

module bstu_mem_model (
    input wire logic pclk, // core clock
    input wire logic presetn, // reset, low
    input wire logic [3:0] wait_cyc, // wait cycles before ack
    input wire logic mem_req, // request
    input wire logic mem_we, // write
    input wire logic [31:0] mem_addr, // byte address
    input wire logic [31:0] mem_wdata, // write data
    output logic [31:0] mem_rdata, // read data
    output logic mem_ack // access done
);
    logic [31:0] store [logic [31:0]];
    logic [31:0] last_raddr;
    logic [3:0] cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            mem_rdata <= 32'h0;
            last_raddr <= 32'h0;
        end else if (mem_ack) begin
            // write lands on the accepting edge
            if (mem_req && mem_we) begin
                store[mem_addr] = mem_wdata;
            end
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt <= 4'h0;
        end else if (mem_req && cnt == wait_cyc) begin
            mem_ack <= 1'b1;
            last_raddr <= mem_addr;
            mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : ~mem_addr;
        end else if (mem_req) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : bstu_mem_model

`default_nettype wire

// [sim/test_branch_and_soft_trap_unit.sv]
/*
 * Self-checking bench: branches, calls, return and both traps over APB.
 * Assumes the memory model and the design sources are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bstu_map.svh"

module test_branch_and_soft_trap_unit;
    import bstu_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic mem_req, mem_we, mem_ack, exception_event;
    logic [31:0] paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata, stack_pointer, rd;
    logic [3:0] wait_cyc;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    int reqc = 0;
    int t0 = 0;

    bstu_branch_trap uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .stack_pointer(stack_pointer), .exception_event(exception_event));
    bstu_mem_model dmem (.pclk(pclk), .presetn(presetn), .wait_cyc(wait_cyc),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    always @(negedge pclk) begin
        if (mem_req === 1'b1) reqc++;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= we;
        paddr <= {20'h0, a};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        t0 = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask : rdchk

    // event pulse follows completion; traps add every request cycle
    task automatic run_op(input logic [31:0] cmd, input int base);
        int r0;
        int tc;
        r0 = reqc;
        apb(1'b1, `BSTU_OFF_CMD, cmd);
        tc = t0;
        for (int i = 0; i < 300 && exception_event !== 1'b1; i++) @(negedge pclk);
        check("op cycles", 32'(base + reqc - r0 + 1), 32'(cyc - tc));
    endtask : run_op

    task automatic opchk(input logic [31:0] cmd, input logic [31:0] eip, input logic [31:0] el);
        run_op(cmd, 2);
        rdchk("ip", `BSTU_OFF_IP, eip);
        rdchk("link", `BSTU_OFF_LINK, el);
        rdchk("psw", `BSTU_OFF_PSW, 32'h0015_002f);
    endtask : opchk

    task automatic t_reset();
        rdchk("ip rst", `BSTU_OFF_IP, `BSTU_RST_IP);
        rdchk("psw rst", `BSTU_OFF_PSW, `BSTU_RST_PSW);
        rdchk("tbr rst", `BSTU_OFF_TBR, `BSTU_RST_TBR);
        rdchk("status rst", `BSTU_OFF_STATUS, 32'h0);
        check("mapped err", 32'h0, {31'h0, err});
    endtask : t_reset

    task automatic t_branches();
        apb(1'b1, `BSTU_OFF_CTRL, 32'h1);
        apb(1'b1, `BSTU_OFF_PSW, 32'h0015_002f);
        apb(1'b1, `BSTU_OFF_USP, 32'h4000_0000);
        apb(1'b1, `BSTU_OFF_IP, 32'h0000_1000);
        apb(1'b1, `BSTU_OFF_GPSRC, 32'h0000_2468);
        opchk(32'h0400_0002, 32'h0000_0802, 32'h0000_1002);
        opchk(32'h0000_0003, 32'h0000_2468, 32'h0000_0804);
        apb(1'b1, `BSTU_OFF_GPSRC, 32'h0000_3000);
        opchk(32'h0000_0001, 32'h0000_3000, 32'h0000_0804);
        opchk(32'h0000_0004, 32'h0000_0804, 32'h0000_0804);
        opchk(32'h03ff_0002, 32'h0000_1004, 32'h0000_0806);
        @(negedge pclk);
        check("sp user", 32'h4000_0000, stack_pointer);
    endtask : t_branches

    task automatic trap_setup(input logic [3:0] w, input logic [31:0] va, input logic [31:0] v);
        wait_cyc <= w;
        dmem.store[va] = v;
        apb(1'b1, `BSTU_OFF_SSP, 32'h8000_0000);
        apb(1'b1, `BSTU_OFF_PSW, 32'h0015_003f);
        apb(1'b1, `BSTU_OFF_IP, 32'h8088_8086);
    endtask : trap_setup

    task automatic stack_chk(input logic [31:0] va, input logic [31:0] v, input logic [31:0] ps);
        rdchk("trap ip", `BSTU_OFF_IP, v);
        check("vec addr", va, dmem.last_raddr);
        rdchk("trap psw", `BSTU_OFF_PSW, ps);
        rdchk("ssp", `BSTU_OFF_SSP, 32'h7fff_fff8);
        rdchk("usp", `BSTU_OFF_USP, 32'h4000_0000);
        check("push ps", 32'h0015_003f, dmem.store[32'h7fff_fffc]);
        check("push ip", 32'h8088_8088, dmem.store[32'h7fff_fff8]);
        @(negedge pclk);
        check("sp sys", 32'h7fff_fff8, stack_pointer);
    endtask : stack_chk

    task automatic t_soft_trap(input logic [7:0] vec, input logic [3:0] w);
        logic [31:0] va;
        va = 32'h000f_fffc - {22'h0, vec, 2'b00};
        trap_setup(w, va, 32'h6809_6800 + {24'h0, vec});
        run_op({16'h0, vec, 8'h05}, 3);
        stack_chk(va, 32'h6809_6800 + {24'h0, vec}, 32'h0015_000f);
    endtask : t_soft_trap

    task automatic t_debug_trap(input logic [3:0] w);
        trap_setup(w, 32'h000f_ffd8, 32'h1357_9bd0);
        apb(1'b1, `BSTU_OFF_CMD, 32'h0000_0006);
        repeat (3 + 3 * (w + 2) + 4) begin
            @(negedge pclk);
            check("no step event", 32'h0, {31'h0, exception_event});
        end
        rdchk("status done", `BSTU_OFF_STATUS, 32'h0000_0002);
        stack_chk(32'h000f_ffd8, 32'h1357_9bd0, 32'h0004_001f);
    endtask : t_debug_trap

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        wait_cyc = 4'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        apb(1'b0, 12'hffc, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        t_branches();
        // vectors kept clear of the reserved debug numbers
        t_soft_trap(8'h20, 4'h1);
        t_soft_trap(8'hff, 4'h0);
        t_debug_trap(4'h2);
        end_of_test();
    end
endmodule : test_branch_and_soft_trap_unit

`default_nettype wire
